// >>> hdl/ltpc_top.sv
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module ltpc_top
   import ltpc_pkg::*;
#(
   parameter int              CH          = 2,
   parameter longint unsigned IDLE_LIMIT  = IDLE_CYCLES,
   parameter longint unsigned WAKE_LIMIT  = WAKE_CYCLES
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          ce,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [31:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   output logic               irq,
   input  wire logic          force_on_pin,
   input  wire logic          force_off_n_pin,
   input  wire logic [CH-1:0] tx_logic_in,
   output logic [CH-1:0]      tx_line_out,
   output logic [CH-1:0]      tx_line_oe,
   input  wire logic [CH-1:0] rx_line_in,
   input  wire logic [CH-1:0] rx_line_valid,
   output logic [CH-1:0]      rx_logic_out,
   output logic [CH-1:0]      rx_logic_oe,
   output logic               line_present_flag,
   output logic               charge_pump_en
);

   localparam int WAKE_W = 16;

   initial begin
      if (CH < 1 || CH > 8) $error("ltpc_top: CH out of range");
      if (IDLE_LIMIT < 1 || IDLE_LIMIT > 64'hFFFF_FFFF) $error("ltpc_top: bad IDLE_LIMIT");
      if (WAKE_LIMIT < 1 || WAKE_LIMIT > WAKE_MAX_CYC) $error("ltpc_top: bad WAKE_LIMIT");
   end

   function automatic logic [IRQ_W-1:0] irq_update(input logic [IRQ_W-1:0] cur,
                                                     input logic [IRQ_W-1:0] clr,
                                                     input logic [IRQ_W-1:0] evt);
      // A new event in the clearing cycle survives the clear
      irq_update = (cur & ~clr) | evt;
   endfunction

   // ==========================================================
   // Force pin decode
   // ==========================================================
   logic [CTRL_W-1:0] ctrl;
   logic              eff_off;
   logic              eff_on;

   assign eff_off = !force_off_n_pin || ctrl[CTRL_FORCE_OFF];
   assign eff_on  = force_on_pin || ctrl[CTRL_FORCE_ON];

   // ==========================================================
   // Activity sensing
   // ==========================================================
   logic              activity;
   logic              expired;
   logic [31:0]       idle_count;
   ltpc_state_t       state;
   ltpc_state_t       next_state;

   // Open receivers are masked so a floating input cannot wake the pump
   ltpc_edge_detect #(
      .W        (2 * CH)
   ) u_edge (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .sense    ({tx_logic_in, rx_line_in & rx_line_valid}),
      .activity (activity)
   );

   ltpc_idle_timer #(
      .CNT_W    (32),
      .LIMIT    (IDLE_LIMIT)
   ) u_idle (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .run      (state == ltpc_active && !eff_on),
      .restart  (activity || state != ltpc_active || eff_on),
      .expired  (expired),
      .count    (idle_count)
   );

   // ==========================================================
   // Power state machine
   // ==========================================================
   logic [WAKE_W-1:0] wake_cnt;
   logic [WAKE_W-1:0] next_wake_cnt;

   always_comb begin
      next_state    = state;
      next_wake_cnt = '0;
      if (eff_off) begin
         next_state = ltpc_off;
      end else begin
         unique case (state)
            ltpc_off: begin
               next_state = ltpc_waking;
            end
            ltpc_active: begin
               if (expired && !eff_on && !activity) next_state = ltpc_auto_pd;
            end
            ltpc_auto_pd: begin
               if (activity || eff_on) next_state = ltpc_waking;
            end
            ltpc_waking: begin
               if (wake_cnt == WAKE_W'(WAKE_LIMIT - 1)) begin
                  next_state = ltpc_active;
               end else begin
                  next_wake_cnt = wake_cnt + WAKE_W'(1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= ltpc_off;
         wake_cnt <= '0;
      end else if (ce) begin
         state    <= next_state;
         wake_cnt <= next_wake_cnt;
      end
   end

   // ==========================================================
   // Line and logic outputs
   // ==========================================================
   logic [CH-1:0] next_tx_line_out;
   logic [CH-1:0] next_tx_line_oe;
   logic [CH-1:0] next_rx_logic_out;
   logic [CH-1:0] next_rx_logic_oe;
   logic          next_line_present;
   logic          next_pump_en;

   always_comb begin
      next_tx_line_out  = ~tx_logic_in;
      next_tx_line_oe   = {CH{next_state == ltpc_active}};
      // Receivers ignore the auto powerdown state entirely
      next_rx_logic_out = (~rx_line_in & rx_line_valid) | ~rx_line_valid;
      next_rx_logic_oe  = {CH{!eff_off}};
      next_line_present = |rx_line_valid;
      next_pump_en      = next_state == ltpc_active || next_state == ltpc_waking;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_line_out       <= '0;
         tx_line_oe        <= '0;
         rx_logic_out      <= '1;
         rx_logic_oe       <= '0;
         line_present_flag <= 1'b0;
         charge_pump_en    <= 1'b0;
      end else if (ce) begin
         tx_line_out       <= next_tx_line_out;
         tx_line_oe        <= next_tx_line_oe;
         rx_logic_out      <= next_rx_logic_out;
         rx_logic_oe       <= next_rx_logic_oe;
         line_present_flag <= next_line_present;
         charge_pump_en    <= next_pump_en;
      end
   end

   // ==========================================================
   // Interrupt events
   // ==========================================================
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_evt;
   logic [IRQ_W-1:0] irq_clr;

   always_comb begin
      irq_evt                = '0;
      irq_evt[IRQ_POWERDOWN] = state != ltpc_auto_pd && next_state == ltpc_auto_pd;
      irq_evt[IRQ_WAKE]      = state == ltpc_waking && next_state == ltpc_active;
      irq_evt[IRQ_LINE_UP]   = !line_present_flag && next_line_present;
      irq_evt[IRQ_LINE_DOWN] = line_present_flag && !next_line_present;
   end

   // ==========================================================
   // APB slave
   // ==========================================================
   // One wait state keeps prdata and pready straight from flops
   logic              acc;
   logic              wr_en;
   logic [ADDR_W-1:0] addr;
   logic              mapped;
   logic [31:0]       rd_word;
   logic [CTRL_W-1:0] next_ctrl;
   logic [IRQ_W-1:0]  next_irq_stat;
   logic [IRQ_W-1:0]  next_irq_mask;
   logic [31:0]       next_prdata;
   logic              next_pready;
   logic              next_pslverr;
   logic              next_irq;

   assign acc   = psel && penable && !pready;
   assign wr_en = psel && penable && pready && pwrite && !pslverr;
   assign addr  = paddr[ADDR_W-1:0];

   always_comb begin
      mapped  = paddr[31:ADDR_W] == '0;
      rd_word = '0;
      unique case (addr)
         OFS_CTRL:     rd_word[CTRL_W-1:0] = ctrl;
         OFS_STATUS: begin
            rd_word[ST_MODE_LSB +: 2]  = state;
            rd_word[ST_LINE_PRESENT]   = line_present_flag;
            rd_word[ST_PUMP_ON]        = charge_pump_en;
            rd_word[ST_AUTO_ENABLED]   = !eff_off && !eff_on;
         end
         OFS_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat;
         OFS_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
         OFS_IDLE:     rd_word = idle_count;
         default:      mapped = 1'b0;
      endcase
   end

   always_comb begin
      next_pready   = acc;
      next_pslverr  = acc && !mapped;
      next_prdata   = (acc && !pwrite && mapped) ? rd_word : '0;
      next_ctrl     = ctrl;
      next_irq_mask = irq_mask;
      irq_clr       = '0;
      if (wr_en) begin
         unique case (addr)
            OFS_CTRL:     next_ctrl     = pwdata[CTRL_W-1:0];
            OFS_IRQ_STAT: irq_clr       = pwdata[IRQ_W-1:0];
            OFS_IRQ_MASK: next_irq_mask = pwdata[IRQ_W-1:0];
            default:      next_ctrl     = ctrl;
         endcase
      end
      next_irq_stat = irq_update(irq_stat, irq_clr, irq_evt);
      next_irq      = |(next_irq_stat & next_irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= CTRL_RESET;
         irq_stat <= '0;
         irq_mask <= IRQ_MASK_RESET;
         prdata   <= '0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         irq      <= 1'b0;
      end else if (ce) begin
         ctrl     <= next_ctrl;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         prdata   <= next_prdata;
         pready   <= next_pready;
         pslverr  <= next_pslverr;
         irq      <= next_irq;
      end
   end

endmodule

// >>> pkg/ltpc_pkg.sv
package ltpc_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam longint unsigned CLK_HZ       = 100_000_000;
   localparam longint unsigned IDLE_TIME_S  = 30;
   localparam longint unsigned IDLE_MIN_S   = 15;
   localparam longint unsigned IDLE_MAX_S   = 60;
   localparam longint unsigned IDLE_CYCLES  = IDLE_TIME_S * CLK_HZ;
   localparam longint unsigned IDLE_MIN_CYC = IDLE_MIN_S * CLK_HZ;
   localparam longint unsigned IDLE_MAX_CYC = IDLE_MAX_S * CLK_HZ;
   localparam longint unsigned WAKE_TIME_US = 30;
   localparam longint unsigned WAKE_MAX_US  = 150;
   localparam longint unsigned WAKE_CYCLES  = WAKE_TIME_US * CLK_HZ / 1_000_000;
   localparam longint unsigned WAKE_MAX_CYC = WAKE_MAX_US * CLK_HZ / 1_000_000;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_STATUS   = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0]  OFS_IDLE     = 8'h10;

   localparam int          CTRL_W           = 2;
   localparam int          CTRL_FORCE_ON    = 0;
   localparam int          CTRL_FORCE_OFF   = 1;
   localparam logic [1:0]  CTRL_RESET       = 2'h0;

   localparam int          ST_MODE_LSB      = 0;
   localparam int          ST_LINE_PRESENT  = 2;
   localparam int          ST_PUMP_ON       = 3;
   localparam int          ST_AUTO_ENABLED  = 4;

   localparam int          IRQ_W            = 4;
   localparam int          IRQ_POWERDOWN    = 0;
   localparam int          IRQ_WAKE         = 1;
   localparam int          IRQ_LINE_UP      = 2;
   localparam int          IRQ_LINE_DOWN    = 3;
   localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;

   typedef enum logic [1:0] {
      ltpc_off,
      ltpc_active,
      ltpc_auto_pd,
      ltpc_waking
   } ltpc_state_t;

endpackage

// >>> hdl/ltpc_edge_detect.sv
`timescale 1ns/1ps
module ltpc_edge_detect
   import ltpc_pkg::*;
#(
   parameter int W = 4
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] sense,
   output logic              activity
);

   logic [W-1:0] prev;
   logic [W-1:0] next_prev;
   logic         next_activity;

   initial begin
      if (W < 1) $error("ltpc_edge_detect: W must be at least 1");
   end

   always_comb begin
      next_prev     = sense;
      next_activity = |(sense ^ prev);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev     <= '0;
         activity <= 1'b0;
      end else if (ce) begin
         prev     <= next_prev;
         activity <= next_activity;
      end
   end

endmodule

// >>> hdl/ltpc_idle_timer.sv
`timescale 1ns/1ps
module ltpc_idle_timer
   import ltpc_pkg::*;
#(
   parameter int              CNT_W = 32,
   parameter longint unsigned LIMIT = IDLE_CYCLES
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic             run,
   input  wire logic             restart,
   output logic                  expired,
   output logic [CNT_W-1:0]      count
);

   localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

   logic [CNT_W-1:0] next_count;
   logic             next_expired;

   initial begin
      if (LIMIT < 1 || LIMIT > (64'h1 << CNT_W))
         $error("ltpc_idle_timer: LIMIT does not fit CNT_W");
   end

   // Only the time since the most recent edge matters, so every edge starts over
   always_comb begin
      next_count   = count;
      next_expired = expired;
      if (restart) begin
         next_count   = '0;
         next_expired = 1'b0;
      end else if (run && !expired) begin
         if (count == LAST) begin
            next_expired = 1'b1;
         end else begin
            next_count = count + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count   <= '0;
         expired <= 1'b0;
      end else if (ce) begin
         count   <= next_count;
         expired <= next_expired;
      end
   end

endmodule

// >>> tb/ltpc_top_sva.sv
`timescale 1ns/1ps
module ltpc_top_sva
   import ltpc_pkg::*;
#(
   parameter int              CH         = 2,
   parameter longint unsigned IDLE_LIMIT = IDLE_CYCLES,
   parameter longint unsigned WAKE_LIMIT = WAKE_CYCLES
) (
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pready,
   input wire logic          force_on_pin,
   input wire logic          force_off_n_pin,
   input wire logic [CH-1:0] tx_logic_in,
   input wire logic [CH-1:0] tx_line_out,
   input wire logic [CH-1:0] tx_line_oe,
   input wire logic [CH-1:0] rx_line_in,
   input wire logic [CH-1:0] rx_line_valid,
   input wire logic [CH-1:0] rx_logic_out,
   input wire logic [CH-1:0] rx_logic_oe,
   input wire logic          line_present_flag,
   input wire logic          charge_pump_en
);
   localparam int WK = int'(WAKE_LIMIT) + 3;
   logic [31:0]   idle_cnt;
   logic [31:0]   next_idle_cnt;
   logic [1:0]    on_cnt;
   logic [1:0]    next_on_cnt;
   logic [CH-1:0] tx_q;
   logic [CH-1:0] rx_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Quiet time; open receiver inputs are not activity
   always_comb begin
      next_idle_cnt = idle_cnt + 32'h0000_0001;
      if (tx_logic_in != tx_q || ((rx_line_in & rx_line_valid) ^ rx_q) != '0
          || force_on_pin || !force_off_n_pin) begin
         next_idle_cnt = 32'h0000_0000;
      end
      next_on_cnt = on_cnt + {1'b0, on_cnt != 2'h3};
      if (!force_off_n_pin) begin
         next_on_cnt = 2'h0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt <= '0;
         on_cnt <= '0;
         tx_q <= '0;
         rx_q <= '0;
      end else begin
         idle_cnt <= next_idle_cnt;
         on_cnt <= next_on_cnt;
         tx_q <= tx_logic_in;
         rx_q <= rx_line_in & rx_line_valid;
      end
   end
   // ==========================================================
   // Assertions
   apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
      else $error("pready not in second cycle");
   drv_inv_a: assert property (on_cnt == 2'h3 |=> tx_line_out == ~$past(tx_logic_in))
      else $error("driver output not inverted");
   rx_map_a: assert property (on_cnt == 2'h3 |=>
      rx_logic_out == (~$past(rx_line_in) | ~$past(rx_line_valid)))
      else $error("receiver output wrong");
   flag_a: assert property (1'b1 |=> line_present_flag == |$past(rx_line_valid))
      else $error("line present flag wrong");
   off_a: assert property (!force_off_n_pin [*2] |=>
      tx_line_oe == '0 && rx_logic_oe == '0 && !charge_pump_en)
      else $error("outputs enabled in manual off");
   fall_cause_a: assert property ($fell(tx_line_oe[0]) |->
      !$past(force_on_pin, 2) || !$past(force_off_n_pin) || !$past(force_off_n_pin, 2))
      else $error("drivers off while forced on");
   wake_a: assert property ($rose(charge_pump_en) |-> ##[1:WK] tx_line_oe == '1)
      else $error("wake too slow");
   idle_min_a: assert property (
      $fell(tx_line_oe[0]) && force_off_n_pin && $past(force_off_n_pin)
      |-> idle_cnt >= IDLE_LIMIT - 1 && !charge_pump_en)
      else $error("powerdown too early");
   idle_max_a: assert property (tx_line_oe[0] |-> idle_cnt <= IDLE_LIMIT + WAKE_LIMIT + 8)
      else $error("powerdown missing");
   rx_alive_a: assert property (on_cnt == 2'h3 |-> rx_logic_oe == '1)
      else $error("receivers off outside manual off");
endmodule

bind ltpc_top ltpc_top_sva #(.CH(CH), .IDLE_LIMIT(IDLE_LIMIT), .WAKE_LIMIT(WAKE_LIMIT)) sva_u (
   .pclk, .presetn, .psel, .penable, .pready, .force_on_pin, .force_off_n_pin,
   .tx_logic_in, .tx_line_out, .tx_line_oe, .rx_line_in, .rx_line_valid,
   .rx_logic_out, .rx_logic_oe, .line_present_flag, .charge_pump_en);

// >>> tb/ltpc_host_model.sv
`timescale 1ns/1ps
module ltpc_host_model
   import ltpc_pkg::*;
#(
   parameter int HOLD = 25
) (
   input  wire logic [1:0] tx_req,
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       keep_ready,
   input  wire logic       off_req,
   input  wire logic [1:0] rx_logic_out,
   output logic [1:0]      tx_logic_in,
   output logic            force_on_pin,
   output logic            force_off_n_pin
);
   int          quiet;
   logic [1:0]  rx_q;
   // Never floats a driver input, even in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_logic_in <= 2'h0;
         force_on_pin <= 1'b0;
         force_off_n_pin <= 1'b1;
         quiet <= 0;
         rx_q <= 2'h3;
      end else begin
         tx_logic_in <= tx_req;
         force_off_n_pin <= !off_req;
         rx_q <= rx_logic_out;
         quiet <= (tx_req != tx_logic_in || rx_logic_out != rx_q) ? 0 : quiet + 1;
         force_on_pin <= keep_ready && quiet >= HOLD;
      end
   end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench
   import ltpc_pkg::*;
;
   localparam int IL = 50;
   localparam int WL = 5;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [31:0] paddr, pwdata, prdata, r, seed, v;
   logic        force_on_pin, force_off_n_pin, line_present_flag, charge_pump_en;
   logic [1:0]  tx_logic_in, tx_line_out, tx_line_oe, rx_line_in, rx_line_valid;
   logic [1:0]  rx_logic_out, rx_logic_oe, tx_req, exp_tx, exp_rx;
   logic        keep_ready, off_req, chk_on, flag_on, exp_flag, e;
   int          err_total, checks_done, n, bad;

   ltpc_top #(.IDLE_LIMIT(IL), .WAKE_LIMIT(WL)) dut_u (.pclk, .presetn, .ce(1'b1),
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
      .force_on_pin, .force_off_n_pin, .tx_logic_in, .tx_line_out, .tx_line_oe,
      .rx_line_in, .rx_line_valid, .rx_logic_out, .rx_logic_oe, .line_present_flag,
      .charge_pump_en);
   ltpc_host_model host_u (.pclk, .presetn, .tx_req, .keep_ready, .off_req,
      .rx_logic_out, .tx_logic_in, .force_on_pin, .force_off_n_pin);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ==========================================================
   // Helpers
   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (x !== g) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         $display("[ERR] apb_pready expected 1 seen 0");
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] x, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, x, r & m);
   endtask
   task wait_oe(input logic [1:0] w);
      n = 0;
      while (tx_line_oe !== w && n < 1000) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task hold(input int every);
      bad = 0;
      for (int i = 1; i <= 150; i++) begin
         @(posedge pclk);
         if (i % every == 1) tx_req <= ~tx_req;
         if (tx_line_oe !== 2'h3) bad++;
      end
   endtask
   task results();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================================
   // Reference: outputs follow inputs one cycle later
   always @(posedge pclk) begin
      exp_tx <= ~tx_logic_in;
      exp_rx <= ~rx_line_in | ~rx_line_valid;
      exp_flag <= |rx_line_valid;
   end
   always @(negedge pclk) begin
      if (chk_on) begin
         chk("tx_line_out", exp_tx, tx_line_out);
         chk("rx_logic_out", exp_rx, rx_logic_out);
      end
      if (flag_on) chk("line_present", exp_flag, line_present_flag);
   end
   initial begin
      #400_000;
      err_total++;
      results();
   end
   // ==========================================================
   // Scenarios
   initial begin
      seed = 32'h6e89_258f;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {tx_req, keep_ready, off_req, chk_on, flag_on, err_total, checks_done} = '0;
      rx_line_in = 2'h0;
      rx_line_valid = 2'h3;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      wait_oe(2'h3);
      chk("reset_wake", 1, n <= WL + 4);
      chk_on <= 1'b1;
      flag_on <= 1'b1;
      rd(OFS_STATUS, 32'h1F, 32'h1D, "status");
      rd(OFS_CTRL, 32'hFFFF_FFFF, 32'h0, "ctrl_reset");
      rd(OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0, "mask_reset");
      apb(1'b1, OFS_IRQ_MASK, 32'hFFFF_FFFF);
      rd(OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'hF, "mask_rw");
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      rd(OFS_CTRL, 32'hFFFF_FFFF, 32'h1, "ctrl_rw");
      rd(OFS_STATUS, 32'h10, 32'h0, "status_forced");
      apb(1'b1, OFS_CTRL, 32'h0000_0000);
      rd(32'h0000_0014, 32'hFFFF_FFFF, 32'h0, "unmapped_data");
      chk("unmapped_err", 1, e);
      apb(1'b1, OFS_IRQ_STAT, 32'h0000_000F);
      repeat (200) begin
         @(posedge pclk);
         v = $random(seed);
         tx_req <= v[1:0];
         rx_line_in <= v[3:2];
         rx_line_valid <= v[5:4];
      end
      wait_oe(2'h0);
      chk("idle_time", 1, n >= IL - 4 && n <= IL + 6);
      repeat (2) @(posedge pclk);
      chk("pump_off", 0, charge_pump_en);
      chk("rx_alive", 3, rx_logic_oe);
      chk("irq_pd", 1, irq);
      tx_req <= ~tx_req;
      wait_oe(2'h3);
      chk("wake_time", 1, n <= WL + 4);
      rd(OFS_IRQ_STAT, 32'h3, 32'h3, "irq_stat");
      apb(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      chk("irq_masked", 0, irq);
      hold(30);
      chk("restart", 0, bad);
      keep_ready <= 1'b1;
      hold(1000);
      chk("forced_on", 0, bad);
      off_req <= 1'b1;
      keep_ready <= 1'b0;
      chk_on <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("off_oe", 0, {tx_line_oe, rx_logic_oe, charge_pump_en});
      rd(OFS_STATUS, 32'h3, 32'h0, "off_state");
      rx_line_valid <= 2'h0;
      repeat (3) @(posedge pclk);
      chk("flag_open", 0, line_present_flag);
      off_req <= 1'b0;
      wait_oe(2'h3);
      chk_on <= 1'b1;
      repeat (10) @(posedge pclk);
      results();
   end
endmodule
